/* File: src/ppq_qualifier.sv */
/*
 * pacemaker pulse qualifier: amplitude, rise time and duration checks
 * feeding a valid pulse flag, with both counts offered for readback.
 * assumes the conditioned signal magnitude, its sign and the rise
 * pulse arrive asynchronously on pins; threshold writes come from the
 * host side logic on the system clock.
 */
`default_nettype none
module ppq_qualifier #(
	parameter int unsigned FLAG_HOLD_CYC = ppq_pkg::FLAG_HOLD_CYC
) (
	// clock and reset
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_sys_rst,
	// asynchronous pins
	input  wire logic [ppq_pkg::THR_W-1:0] i_sig_mag,
	input  wire logic                    i_sig_neg,
	input  wire logic                    i_rise_pulse,
	input  wire logic                    i_ext_reset,
	// threshold channel write, system clock domain
	input  wire logic                    i_thr_wr,
	input  wire logic [2:0]              i_thr_ch,
	input  wire logic [ppq_pkg::THR_W-1:0] i_thr_code,
	// results
	output logic                         o_pace_valid,
	output logic                         o_counter_clear,
	output logic [ppq_pkg::CNT_W-1:0]    o_rise_count,
	output logic [ppq_pkg::CNT_W-1:0]    o_dur_count
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	// multi-bit magnitude may tear for one cycle; the compare tolerates
	// it because a pulse lasts many system clocks
	logic [ppq_pkg::SYNC_W-1:0] sync1_r; // first stage only
	logic [ppq_pkg::SYNC_W-1:0] sync2_r; // safe to use
	logic [ppq_pkg::THR_W-1:0]  mag_s;   // synced magnitude
	logic                       neg_s;   // synced sign
	logic                       rise_s;  // synced rise pulse
	logic                       xrst_s;  // synced external reset

	// two flip-flops, nothing reads the first
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {i_ext_reset, i_rise_pulse, i_sig_neg, i_sig_mag};
			sync2_r <= sync1_r;
		end
	end
	assign mag_s  = sync2_r[ppq_pkg::THR_W-1:0];
	assign neg_s  = sync2_r[ppq_pkg::THR_W];
	assign rise_s = sync2_r[ppq_pkg::THR_W+1];
	assign xrst_s = sync2_r[ppq_pkg::THR_W+2];

	// ************************************************************
	// threshold store
	// ************************************************************
	ppq_pkg::ppq_thr_t thr_r;   // held codes
	ppq_pkg::ppq_thr_t thr_nxt; // next codes

	// one channel per write; zero until written
	always_comb begin
		thr_nxt = thr_r;
		if (i_thr_wr) begin
			case (i_thr_ch)
				ppq_pkg::CH_AMP:    thr_nxt.amplitude_threshold = i_thr_code;
				ppq_pkg::CH_RT_LO:
					thr_nxt.rise_time_lower_threshold = i_thr_code;
				ppq_pkg::CH_RT_HI:
					thr_nxt.rise_time_upper_threshold = i_thr_code;
				ppq_pkg::CH_DUR_LO:
					thr_nxt.duration_lower_threshold = i_thr_code;
				ppq_pkg::CH_DUR_HI:
					thr_nxt.duration_upper_threshold = i_thr_code;
				ppq_pkg::CH_POL:    thr_nxt.polarity_invert = i_thr_code;
				default:            thr_nxt = thr_r; // unused channels
			endcase
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			thr_r <= '0;
		end else begin
			thr_r <= thr_nxt;
		end
	end

	// ************************************************************
	// polarity correction and amplitude compare
	// ************************************************************
	logic [ppq_pkg::THR_W-1:0] cond_mag; // corrected signal
	logic                      amp_hi;   // above amplitude threshold
	// negative input passes as magnitude only when inversion is on
	always_comb begin
		cond_mag = mag_s;
		if (neg_s && (thr_r.polarity_invert == '0)) begin
			cond_mag = '0; // negative pulses ignored
		end
	end
	assign amp_hi = (cond_mag >= thr_r.amplitude_threshold);

	// ************************************************************
	// derived counter clocks
	// ************************************************************
	logic [31:0] rise_acc_r;   // rise clock phase
	logic [31:0] rise_acc_nxt; // next rise phase
	logic [31:0] dur_acc_r;    // duration clock phase
	logic [31:0] dur_acc_nxt;  // next duration phase
	logic        rise_fall;    // falling edge of rise clock
	logic        dur_fall;     // falling edge of duration clock

	// phase accumulators, msb is the clock
	always_comb begin
		rise_acc_nxt = rise_acc_r + ppq_pkg::RISE_INC;
		dur_acc_nxt  = dur_acc_r + ppq_pkg::DUR_INC;
	end
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			rise_acc_r <= '0;
			dur_acc_r  <= '0;
		end else begin
			rise_acc_r <= rise_acc_nxt;
			dur_acc_r  <= dur_acc_nxt;
		end
	end
	// high-to-low of each derived clock
	assign rise_fall = rise_acc_r[ppq_pkg::ACC_MSB]
		& ~rise_acc_nxt[ppq_pkg::ACC_MSB];
	assign dur_fall = dur_acc_r[ppq_pkg::ACC_MSB]
		& ~dur_acc_nxt[ppq_pkg::ACC_MSB];

	// ************************************************************
	// qualification sequence
	// ************************************************************
	ppq_pkg::ppq_state_t        state_r;     // current step
	ppq_pkg::ppq_state_t        state_nxt;   // next step
	logic                       amp_seen_r;  // amplitude passed
	logic                       amp_seen_nxt;
	logic [31:0]                hold_r;      // flag hold timer
	logic [31:0]                hold_nxt;
	logic                       rise_in_win; // rise window pass
	logic                       dur_in_win;  // duration window pass
	logic                       clr;         // counter_clear level
	logic                       rise_en;     // rise clock gate
	logic                       dur_en;      // duration clock gate
	logic [ppq_pkg::CNT_W-1:0]  rise_cnt_r;  // rise stages
	logic [ppq_pkg::CNT_W-1:0]  dur_cnt_r;   // duration stages
	logic [ppq_pkg::CNT_W-1:0]  rise_cnt_nxt;
	logic [ppq_pkg::CNT_W-1:0]  dur_cnt_nxt;
	logic [ppq_pkg::CNT_W:0]    rise_cy;     // ripple carries
	logic [ppq_pkg::CNT_W:0]    dur_cy;

	// window compares on the upper counter stages
	assign rise_in_win =
		(rise_cnt_r[ppq_pkg::CNT_W-1:ppq_pkg::CMP_LSB]
			>= thr_r.rise_time_lower_threshold) &&
		(rise_cnt_r[ppq_pkg::CNT_W-1:ppq_pkg::CMP_LSB]
			<= thr_r.rise_time_upper_threshold);
	// duration window
	assign dur_in_win =
		(dur_cnt_r[ppq_pkg::CNT_W-1:ppq_pkg::CMP_LSB]
			>= thr_r.duration_lower_threshold) &&
		(dur_cnt_r[ppq_pkg::CNT_W-1:ppq_pkg::CMP_LSB]
			<= thr_r.duration_upper_threshold);

	// step logic
	always_comb begin
		state_nxt    = state_r;
		amp_seen_nxt = amp_seen_r;
		hold_nxt     = hold_r;
		case (state_r)
			ppq_pkg::S_IDLE: begin
				// counters held clear here
				amp_seen_nxt = 1'b0;
				if (rise_s) begin
					state_nxt    = ppq_pkg::S_RISE;
					amp_seen_nxt = amp_hi;
				end
			end
			ppq_pkg::S_RISE: begin
				// amplitude watched during timing
				amp_seen_nxt = amp_seen_r | amp_hi;
				if (!rise_s) begin
					// both must pass to go on
					if (amp_seen_r && rise_in_win && amp_hi) begin
						state_nxt = ppq_pkg::S_DUR;
					end else begin
						state_nxt = ppq_pkg::S_IDLE;
					end
				end
			end
			ppq_pkg::S_DUR: begin
				if (!amp_hi) begin
					if (dur_in_win) begin
						state_nxt = ppq_pkg::S_FLAG;
						hold_nxt  = '0;
					end else begin
						state_nxt = ppq_pkg::S_IDLE;
					end
				end
			end
			ppq_pkg::S_FLAG: begin
				// external or internal reset rearms
				hold_nxt = hold_r + 32'h0000_0001;
				if (xrst_s || (hold_r >= 32'(FLAG_HOLD_CYC - 1))) begin
					state_nxt = ppq_pkg::S_IDLE;
				end
			end
			default: state_nxt = ppq_pkg::S_IDLE;
		endcase
	end

	// clear is a level taken straight from the step, so it reaches
	// the stages in the same cycle
	assign clr     = (state_r == ppq_pkg::S_IDLE);
	assign rise_en = (state_r == ppq_pkg::S_RISE) && rise_s;
	assign dur_en  = (state_r == ppq_pkg::S_DUR);
	assign rise_cy[0] = rise_fall & rise_en;
	assign dur_cy[0]  = dur_fall & dur_en;

	// each stage toggles when all lower stages are high
	// wraps at full scale just as the discrete ripple part does
	for (genvar gi = 0; gi < ppq_pkg::CNT_W; gi++) begin : g_stage
		assign rise_cy[gi+1]    = rise_cy[gi] & rise_cnt_r[gi];
		assign dur_cy[gi+1]     = dur_cy[gi] & dur_cnt_r[gi];
		assign rise_cnt_nxt[gi] = ~clr & (rise_cnt_r[gi] ^ rise_cy[gi]);
		assign dur_cnt_nxt[gi]  = ~clr & (dur_cnt_r[gi] ^ dur_cy[gi]);
	end

	// register the step, counters and outputs
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			state_r         <= ppq_pkg::S_IDLE;
			amp_seen_r      <= 1'b0;
			hold_r          <= '0;
			rise_cnt_r      <= '0;
			dur_cnt_r       <= '0;
			o_pace_valid    <= 1'b0;
			o_counter_clear <= 1'b1;
			o_rise_count    <= '0;
			o_dur_count     <= '0;
		end else begin
			state_r         <= state_nxt;
			amp_seen_r      <= amp_seen_nxt;
			hold_r          <= hold_nxt;
			rise_cnt_r      <= rise_cnt_nxt;
			dur_cnt_r       <= dur_cnt_nxt;
			o_pace_valid    <= (state_nxt == ppq_pkg::S_FLAG);
			o_counter_clear <= (state_nxt == ppq_pkg::S_IDLE);
			o_rise_count    <= rise_cnt_nxt;
			o_dur_count     <= dur_cnt_nxt;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	property p_rise_gate;
		(state_r != ppq_pkg::S_IDLE) && !rise_cy[0]
			|=> rise_cnt_r == $past(rise_cnt_r);
	endproperty
	a_rise_gate: assert property (p_rise_gate)
		else $error("rise count moved without gated clock edge");

	property p_rise_win;
		(state_r == ppq_pkg::S_RISE) && !rise_s && !rise_in_win
			|=> state_r == ppq_pkg::S_IDLE;
	endproperty
	a_rise_win: assert property (p_rise_win)
		else $error("rise outside window not rejected");

	property p_dur_start;
		(state_r == ppq_pkg::S_RISE) ##1 (state_r == ppq_pkg::S_DUR)
			|-> $past(amp_seen_r) && $past(rise_in_win);
	endproperty
	a_dur_start: assert property (p_dur_start)
		else $error("duration started without both checks");

	property p_dur_gate;
		(state_r != ppq_pkg::S_DUR) |=> dur_cnt_r == '0 ||
			dur_cnt_r == $past(dur_cnt_r);
	endproperty
	a_dur_gate: assert property (p_dur_gate)
		else $error("duration count moved outside duration step");

	property p_dur_win;
		(state_r == ppq_pkg::S_DUR) && !amp_hi && dur_in_win
			|=> o_pace_valid;
	endproperty
	a_dur_win: assert property (p_dur_win)
		else $error("valid duration did not raise flag");

	property p_flag_cause;
		$rose(o_pace_valid) |->
			$past(state_r == ppq_pkg::S_DUR) && $past(dur_in_win);
	endproperty
	a_flag_cause: assert property (p_flag_cause)
		else $error("flag rose without passing duration");

	property p_clear;
		(state_r == ppq_pkg::S_IDLE) |=>
			(rise_cnt_r == '0) && (dur_cnt_r == '0);
	endproperty
	a_clear: assert property (p_clear)
		else $error("counters not cleared in idle");

	property p_rearm;
		(state_r == ppq_pkg::S_FLAG) && xrst_s
			|=> !o_pace_valid ##1 o_counter_clear;
	endproperty
	a_rearm: assert property (p_rearm)
		else $error("external reset did not rearm block");

	property p_thr_zero;
		$fell(i_sys_rst) |-> thr_r == '0;
	endproperty
	a_thr_zero: assert property (p_thr_zero)
		else $error("thresholds not zero after reset");

	c_flag: cover property ($rose(o_pace_valid));
	c_rise_reject: cover property ((state_r == ppq_pkg::S_RISE)
		##1 (state_r == ppq_pkg::S_IDLE));
	c_dur_reject: cover property ((state_r == ppq_pkg::S_DUR)
		##1 (state_r == ppq_pkg::S_IDLE));
endmodule
`default_nettype wire

/* File: src/ppq_pkg.sv */
/*
 * constants, types and states of the pacemaker pulse qualifier.
 * assumes a single 50 MHz system clock and threshold codes from a host.
 */
// What this block does
// - rise counter runs only while rise pulse high
// - rise valid only inside rise threshold window
// - amplitude checked in parallel with rise timing
// - duration counts only after amplitude and rise pass
// - duration counted on separate slower clock
// - duration valid only inside duration threshold window
// - all checks pass raises valid pulse flag
// - twelve bit ripple counters, all stages visible
// - counter clear zeroes counter on next system clock edge, without derived clock edge
// - counters advance on falling clock edge
// - polarity invert passes positive, inverts negative input
// - measured counts offered to converter for host
// - thresholds hold zero until host writes code
// - rise clock runs at 1.75 MHz
// - duration clock runs at 806 kHz
// - reset after flag returns block to idle
`default_nettype none
package ppq_pkg;
	// ************************************************************
	// clocks and rates
	// ************************************************************
	localparam int unsigned SYS_CLK_HZ  = 50_000_000; // system clock
	localparam int unsigned RISE_CLK_HZ = 1_750_000;  // rise clock
	localparam int unsigned DUR_CLK_HZ  = 806_000;    // duration clock
	localparam int unsigned ACC_W       = 32;         // phase width
	localparam int unsigned ACC_MSB     = ACC_W - 1;  // phase msb
	// phase steps; msb of the accumulator is the derived clock
	localparam logic [31:0] RISE_INC =
		32'((64'(RISE_CLK_HZ) << ACC_W) / 64'(SYS_CLK_HZ));
	localparam logic [31:0] DUR_INC =
		32'((64'(DUR_CLK_HZ) << ACC_W) / 64'(SYS_CLK_HZ));
	// internal reset: flag held this long, then block rearms
	localparam int unsigned FLAG_HOLD_US  = 1000;
	localparam int unsigned FLAG_HOLD_CYC =
		FLAG_HOLD_US * (SYS_CLK_HZ / 1_000_000);

	// ************************************************************
	// widths and channel codes
	// ************************************************************
	localparam int unsigned CNT_W   = 12; // counter stages
	localparam int unsigned THR_W   = 8;  // dac code width
	localparam int unsigned CMP_LSB = CNT_W - THR_W; // count scaling
	localparam int unsigned SYNC_W  = THR_W + 3; // synced pin bits
	localparam logic [2:0] CH_AMP    = 3'h0; // amplitude_threshold
	localparam logic [2:0] CH_RT_LO  = 3'h1; // rise lower
	localparam logic [2:0] CH_RT_HI  = 3'h2; // rise upper
	localparam logic [2:0] CH_DUR_LO = 3'h3; // duration lower
	localparam logic [2:0] CH_DUR_HI = 3'h4; // duration upper
	localparam logic [2:0] CH_POL    = 3'h5; // polarity invert

	// threshold set as held inside the block
	typedef struct packed {
		logic [7:0] amplitude_threshold;
		logic [7:0] rise_time_lower_threshold;
		logic [7:0] rise_time_upper_threshold;
		logic [7:0] duration_lower_threshold;
		logic [7:0] duration_upper_threshold;
		logic [7:0] polarity_invert;
	} ppq_thr_t;

	// qualification sequence
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_RISE = 2'b01,
		S_DUR  = 2'b10,
		S_FLAG = 2'b11
	} ppq_state_t;
endpackage
`default_nettype wire

/* File: sim/ppq_host_model.sv */
/*
 * host side model: writes threshold codes and reads back both counts.
 * assumes the bench asks for one write at a time on i_req.
 */
`default_nettype none
module ppq_host_model (
	// clock
	input  wire logic                      i_sys_clk,
	// bench request
	input  wire logic                      i_req,
	input  wire logic [2:0]                i_ch,
	input  wire logic [ppq_pkg::THR_W-1:0] i_code,
	// block results
	input  wire logic                      i_pace_valid,
	input  wire logic [ppq_pkg::CNT_W-1:0] i_rise_count,
	input  wire logic [ppq_pkg::CNT_W-1:0] i_dur_count,
	// threshold port
	output logic                           o_thr_wr,
	output logic [2:0]                     o_thr_ch,
	output logic [ppq_pkg::THR_W-1:0]      o_thr_code,
	// counts as read back
	output logic [ppq_pkg::CNT_W-1:0]      o_rise_seen,
	output logic [ppq_pkg::CNT_W-1:0]      o_dur_seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic flag_q; // last flag level, edge finder
	initial begin
		o_thr_wr    = 1'b0;
		o_thr_ch    = 3'h0;
		o_thr_code  = 8'h00;
		o_rise_seen = 12'h000;
		o_dur_seen  = 12'h000;
		flag_q      = 1'b0;
	end
	// one eight bit code per write strobe
	always @(posedge i_sys_clk) begin
		o_thr_wr   <= i_req;
		o_thr_ch   <= i_ch;
		o_thr_code <= i_code;
	end
	// counts read once the flag rises, while they hold
	always @(posedge i_sys_clk) begin
		flag_q <= i_pace_valid;
		if (i_pace_valid && !flag_q) begin
			o_rise_seen <= i_rise_count;
			o_dur_seen  <= i_dur_count;
		end
	end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
/*
 * self checking bench of the pulse qualifier, random pulse widths.
 * assumes a short internal rearm of 200 cycles for quick runs.
 */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD = 200; // shortened rearm time
	logic clk = 1'b0, rst = 1'b1, req = 1'b0, neg = 1'b0;
	logic rp = 1'b0, ext = 1'b0;
	logic [2:0] ch = 3'h0, thr_ch;
	logic [7:0] code = 8'h00, mag = 8'h00, thr_code;
	logic thr_wr, valid, clr;
	logic [11:0] rc, dc, r_seen, d_seen, mid_dur;
	logic [7:0] sh [8]; // shadow of the codes written so far
	int errors = 0, cmp_count = 0;
	always #10 clk = ~clk;
	ppq_qualifier #(.FLAG_HOLD_CYC(HOLD)) i_dut (.i_sys_clk(clk),
		.i_sys_rst(rst), .i_sig_mag(mag), .i_sig_neg(neg),
		.i_rise_pulse(rp), .i_ext_reset(ext), .i_thr_wr(thr_wr),
		.i_thr_ch(thr_ch), .i_thr_code(thr_code), .o_pace_valid(valid),
		.o_counter_clear(clr), .o_rise_count(rc), .o_dur_count(dc));
	ppq_host_model i_host (.i_sys_clk(clk), .i_req(req), .i_ch(ch),
		.i_code(code), .i_pace_valid(valid), .i_rise_count(rc),
		.i_dur_count(dc), .o_thr_wr(thr_wr), .o_thr_ch(thr_ch),
		.o_thr_code(thr_code), .o_rise_seen(r_seen), .o_dur_seen(d_seen));
	// ************************************************************
	// checks and drivers
	// ************************************************************
	task automatic chk(input string n, input logic [11:0] e, g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %0h got %0h", n, e, g);
		end
	endtask
	// derived clocks are not exact, so allow two counts either way
	task automatic near(input string n, input int e, input logic [11:0] g);
		logic ok;
		ok = (g >= 12'(e - 2)) && (g <= 12'(e + 2));
		cmp_count++;
		if (ok !== 1'b1) begin
			errors++;
			$display("CHECK FAILED %s exp %0d got %0d", n, e, g);
		end
	endtask
	// rule based view: does the duration step open for this pulse
	function automatic logic gate_open(input int l, input logic [7:0] m,
		input logic n);
		int top;
		top = (l * 7 / 200) >> ppq_pkg::CMP_LSB;
		return (!n || sh[ppq_pkg::CH_POL] != 8'h00) &&
			(m >= sh[ppq_pkg::CH_AMP]) &&
			(top >= int'(sh[ppq_pkg::CH_RT_LO])) &&
			(top <= int'(sh[ppq_pkg::CH_RT_HI]));
	endfunction
	task automatic wr(input logic [2:0] c, input logic [7:0] v);
		@(posedge clk);
		req <= 1'b1;
		ch <= c;
		code <= v;
		sh[c] = v;
		@(posedge clk);
		req <= 1'b0;
	endtask
	// rise pulse of l cycles, then d cycles of amplitude alone
	task automatic run(input int l, d, input logic [7:0] m,
		input logic n, input logic pass, input logic use_ext);
		@(posedge clk);
		mag <= m;
		neg <= n;
		rp <= 1'b1;
		repeat (l) @(posedge clk);
		rp <= 1'b0;
		repeat (d / 2) @(posedge clk);
		mid_dur = dc;
		repeat (d - d / 2) @(posedge clk);
		mag <= 8'h00;
		neg <= 1'b0;
		repeat (30) @(posedge clk);
		chk("valid", {11'h0, pass}, {11'h0, valid});
		if (!gate_open(l, m, n))
			chk("mid_dur", 12'h000, mid_dur);
		else
			near("mid_dur", d / 2 * 806 / 50000, mid_dur);
		if (pass) begin
			near("rise", l * 7 / 200, r_seen);
			near("dur", d * 806 / 50000, d_seen);
			chk("rise_hold", r_seen, rc);
			chk("dur_hold", d_seen, dc);
		end
		if (pass && use_ext) begin
			ext <= 1'b1;
			repeat (8) @(posedge clk);
			chk("ext_rearm", 12'h000, {11'h0, valid});
			ext <= 1'b0;
		end else if (pass) begin
			repeat (120) @(posedge clk);
			chk("flag_hold", 12'h001, {11'h0, valid});
		end
		repeat (250) @(posedge clk);
		chk("rearm", 12'h000, {11'h0, valid});
		chk("clear", 12'h001, {11'h0, clr});
		chk("rc0", 12'h000, rc);
		chk("dc0", 12'h000, dc);
		$display("test done l=%0d d=%0d", l, d);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ************************************************************
	// watchdog and main sequence
	// ************************************************************
	initial begin
		#(20ns * 90000);
		errors++;
		wrap_up();
	end
	initial begin
		int l, d;
		for (int k = 0; k < 8; k++)
			sh[k] = 8'h00;
		void'($urandom(32'h6907));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("rst_valid", 12'h000, {11'h0, valid});
		chk("rst_clear", 12'h001, {11'h0, clr});
		chk("rst_rc", 12'h000, rc);
		// zero thresholds leave the rise window shut
		run(1000, 3000, 8'h80, 1'b0, 1'b0, 1'b0);
		wr(ppq_pkg::CH_AMP, 8'h40);
		wr(ppq_pkg::CH_RT_LO, 8'h01);
		wr(ppq_pkg::CH_RT_HI, 8'h04);
		wr(ppq_pkg::CH_DUR_LO, 8'h02);
		wr(ppq_pkg::CH_DUR_HI, 8'h05);
		wr(3'h7, 8'hFF); // unmapped channel is ignored
		for (int i = 0; i < 3; i++) begin
			l = 900 + $urandom_range(200);
			d = 2800 + $urandom_range(400);
			run(l, d, 8'(8'h50 + $urandom_range(8'h2F)), 1'b0,
				1'b1, i[0]);
		end
		run(1000, 3000, 8'h20, 1'b0, 1'b0, 1'b0);
		run(200, 3000, 8'h80, 1'b0, 1'b0, 1'b0);
		run(2500, 3000, 8'h80, 1'b0, 1'b0, 1'b0);
		run(1000, 8000, 8'h80, 1'b0, 1'b0, 1'b0);
		run(1000, 1000, 8'h80, 1'b0, 1'b0, 1'b0);
		run(1000, 3000, 8'h80, 1'b1, 1'b0, 1'b0);
		wr(ppq_pkg::CH_POL, 8'h01);
		run(1000, 3000, 8'h80, 1'b1, 1'b1, 1'b1);
		run(1000, 3000, 8'h80, 1'b0, 1'b1, 1'b0);
		wrap_up();
	end
endmodule
`default_nettype wire
